// ===== verilog/resonance_pkg.sv
`default_nettype none
package resonance_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_NOTCH = 4;
  localparam int NUM_STAGES = 6;
  localparam logic [2:0] LAST_STAGE = 3'h5;
  localparam logic [2:0] MID_STAGE = 3'h5;

  // register offsets
  localparam logic [7:0] OFS_LOWPASS_FIRST = 8'h00;
  localparam logic [7:0] OFS_LOWPASS_SECOND = 8'h01;
  localparam logic [7:0] OFS_SECOND_CUTOFF = 8'h02;
  localparam logic [7:0] OFS_SECOND_QUALITY = 8'h03;
  localparam logic [7:0] OFS_AUTO_NOTCH_EN = 8'h04;
  localparam logic [7:0] OFS_MID_SWITCH = 8'h05;
  localparam logic [7:0] OFS_JUDGE_LEVEL = 8'h06;
  localparam logic [7:0] OFS_MID_DETECTED = 8'h07;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] NOTCH_BASE = 8'h10;
  localparam logic [1:0] FLD_FREQ = 2'h0;
  localparam logic [1:0] FLD_QUALITY = 2'h1;
  localparam logic [1:0] FLD_DEPTH = 2'h2;
  localparam int STATUS_GAIN_BIT = 0;
  localparam int STATUS_MID_BIT = 1;

  // ranges and reset values
  localparam logic [15:0] LOWPASS_MIN = 16'h0001;
  localparam logic [15:0] LOWPASS_MAX = 16'h1388;
  localparam logic [15:0] LOWPASS_RST = 16'h0064;
  localparam logic [15:0] NOTCH_FREQ_MIN = 16'h0032;
  localparam logic [15:0] FREQ_MAX = 16'h1388;
  localparam logic [15:0] QUALITY_MIN = 16'h0001;
  localparam logic [15:0] QUALITY_MAX = 16'h0064;
  localparam logic [15:0] NOTCH_QUALITY_RST = 16'h0007;
  localparam logic [15:0] DEPTH_MAX = 16'h003c;
  localparam logic [15:0] DEPTH_RST = 16'h0000;
  localparam logic [15:0] SECOND_CUTOFF_MIN = 16'h0064;
  localparam logic [15:0] SECOND_QUALITY_RST = 16'h0032;
  localparam logic [15:0] JUDGE_LEVEL_RST = 16'h000a;
  localparam logic [15:0] SWITCH_MAX = 16'h0002;
  localparam logic [15:0] MID_SWITCH_ON = 16'h0002;

  // tuner limits
  localparam logic [15:0] AUTO_FREQ_MIN = 16'h012c;
  localparam logic [15:0] MID_FREQ_MIN = 16'h0064;
  localparam logic [15:0] MID_FREQ_MAX = 16'h05dc;
  localparam logic [15:0] AUTO_DEPTH = 16'h0014;
  localparam logic [15:0] MID_DEPTH = 16'h0014;

  // fixed point
  localparam int COEF_FRAC = 14;
  localparam int STATE_FRAC = 12;
  localparam int KEEP_FRAC = 16;
  localparam logic [16:0] KEEP_ONE = 17'h10000;
  localparam logic [16:0] DB_STEP = 17'h0e429;
  localparam longint LOWPASS_UNIT_NS = 10000;

  typedef enum {ST_IDLE, ST_LOWPASS, ST_SHAPE, ST_DONE} state_t;
endpackage : resonance_pkg
`default_nettype wire

// ===== verilog/servo_resonance_suppression.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module servo_resonance_suppression
  import resonance_pkg::*;
#(
  parameter int SAMPLE_HZ = 40000
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output var  logic [DATA_W-1:0]   reg_rdata,
  // torque stream
  input  wire logic                sample_valid,
  input  wire logic signed [15:0]  torque_in,
  input  wire logic signed [15:0]  speed_osc,
  input  wire logic                gain_second,
  output var  logic signed [15:0]  torque_out,
  output var  logic                torque_out_valid
);
  localparam longint TS_NS = 64'd1000000000 / longint'(SAMPLE_HZ);
  localparam longint FREQ_GAIN =
    (64'd628318 * (64'd1 << (COEF_FRAC + 8))) / (64'd100000 * SAMPLE_HZ);

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // fraction of the signal kept at the notch centre
  function automatic logic [16:0] db_keep(input logic [15:0] depth);
    logic [33:0] k;
    k = {17'h0, KEEP_ONE};
    for (int i = 0; i < 60; i++) begin
      if (16'(i) < depth) begin
        k = (k * {17'h0, DB_STEP}) >> KEEP_FRAC;
      end
    end
    db_keep = k[16:0];
  endfunction : db_keep

  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh7fff) begin
      sat16 = 16'sh7fff;
    end else if (v < -32'sh8000) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // reset release
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // settings
  logic [15:0] lowpass_first_q, lowpass_second_q;
  logic [15:0] cutoff_q, second_quality_q;
  logic [15:0] auto_en_q, mid_switch_q, judge_q, mid_freq_q;
  logic        mid_active_q;
  logic [15:0] notch_freq_q  [NUM_NOTCH];
  logic [15:0] notch_qual_q  [NUM_NOTCH];
  logic [15:0] notch_depth_q [NUM_NOTCH];

  // vibration detector
  logic        prev_neg_q;
  logic [15:0] period_q, peak_q;
  logic [15:0] osc_abs, det_freq;
  logic        rising, det_hit, auto_hit, mid_hit, mid_on;
  assign osc_abs  = speed_osc[15] ? 16'(-speed_osc) : 16'(speed_osc);
  assign rising   = sample_valid && prev_neg_q && !speed_osc[15];
  assign det_freq = (period_q == 16'h0) ? 16'h0
                  : 16'(32'(SAMPLE_HZ) / {16'h0, period_q});
  assign det_hit  = rising && (peak_q > judge_q) && (period_q != 16'h0);
  assign auto_hit = det_hit && auto_en_q == 16'h1 &&
                    det_freq > AUTO_FREQ_MIN;
  assign mid_on   = (mid_switch_q == MID_SWITCH_ON);
  assign mid_hit  = det_hit && mid_on && det_freq >= MID_FREQ_MIN &&
                    det_freq <= MID_FREQ_MAX;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_neg_q <= 1'b0;
      period_q   <= 16'h0;
      peak_q     <= 16'h0;
    end else if (sample_valid) begin
      prev_neg_q <= speed_osc[15];
      if (rising) begin
        period_q <= 16'h1;
        peak_q   <= osc_abs;
      end else begin
        period_q <= (period_q == 16'hffff) ? period_q : period_q + 16'h1;
        peak_q   <= (osc_abs > peak_q) ? osc_abs : peak_q;
      end
    end
  end

  // register writes
  logic wr_lp1, wr_lp2, wr_cut, wr_sq, wr_auto, wr_mid, wr_judge;
  assign wr_lp1   = reg_write && reg_addr == OFS_LOWPASS_FIRST;
  assign wr_lp2   = reg_write && reg_addr == OFS_LOWPASS_SECOND;
  assign wr_cut   = reg_write && reg_addr == OFS_SECOND_CUTOFF;
  assign wr_sq    = reg_write && reg_addr == OFS_SECOND_QUALITY;
  assign wr_auto  = reg_write && reg_addr == OFS_AUTO_NOTCH_EN;
  assign wr_mid   = reg_write && reg_addr == OFS_MID_SWITCH;
  assign wr_judge = reg_write && reg_addr == OFS_JUDGE_LEVEL;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lowpass_first_q  <= LOWPASS_RST;
      lowpass_second_q <= LOWPASS_RST;
      cutoff_q         <= FREQ_MAX;
      second_quality_q <= SECOND_QUALITY_RST;
      auto_en_q        <= 16'h0;
      mid_switch_q     <= 16'h0;
      judge_q          <= JUDGE_LEVEL_RST;
      mid_freq_q       <= 16'h0;
      mid_active_q     <= 1'b0;
    end else begin
      if (wr_lp1) lowpass_first_q <= clamp(reg_wdata, LOWPASS_MIN, LOWPASS_MAX);
      if (wr_lp2) lowpass_second_q <= clamp(reg_wdata, LOWPASS_MIN, LOWPASS_MAX);
      if (wr_cut) cutoff_q <= clamp(reg_wdata, SECOND_CUTOFF_MIN, FREQ_MAX);
      if (wr_sq) second_quality_q <= clamp(reg_wdata, QUALITY_MIN, QUALITY_MAX);
      if (wr_auto) auto_en_q <= {15'h0, reg_wdata[0]};
      if (wr_mid) mid_switch_q <= clamp(reg_wdata, 16'h0, SWITCH_MAX);
      if (wr_judge) judge_q <= reg_wdata;
      if (mid_hit) begin
        mid_freq_q   <= det_freq;
        mid_active_q <= 1'b1;
      end
    end
  end

  for (genvar n = 0; n < NUM_NOTCH; n++) begin : g_notch
    localparam logic [7:0] BASE = NOTCH_BASE + 8'(4 * n);
    logic wr_f, wr_q, wr_d, tune;
    assign wr_f = reg_write && reg_addr == BASE + {6'h0, FLD_FREQ};
    assign wr_q = reg_write && reg_addr == BASE + {6'h0, FLD_QUALITY};
    assign wr_d = reg_write && reg_addr == BASE + {6'h0, FLD_DEPTH};
    assign tune = (n == 0) && auto_hit;
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        notch_freq_q[n]  <= FREQ_MAX;
        notch_qual_q[n]  <= NOTCH_QUALITY_RST;
        notch_depth_q[n] <= DEPTH_RST;
      end else begin
        if (tune) begin
          notch_freq_q[n] <= clamp(det_freq, NOTCH_FREQ_MIN, FREQ_MAX);
        end else if (wr_f) begin
          notch_freq_q[n] <= clamp(reg_wdata, NOTCH_FREQ_MIN, FREQ_MAX);
        end
        if (wr_q) notch_qual_q[n] <= clamp(reg_wdata, QUALITY_MIN, QUALITY_MAX);
        if (tune && notch_depth_q[n] == DEPTH_RST) begin
          notch_depth_q[n] <= AUTO_DEPTH;
        end else if (wr_d) begin
          notch_depth_q[n] <= clamp(reg_wdata, 16'h0, DEPTH_MAX);
        end
      end
    end
  end

  // register reads
  logic [1:0]  rd_idx;
  logic        rd_notch;
  logic [15:0] rd_val, rdata_q;
  assign rd_idx   = reg_addr[3:2];
  assign rd_notch = reg_addr[7:4] == NOTCH_BASE[7:4];
  always_comb begin
    rd_val = 16'h0;
    if (rd_notch) begin
      unique case (reg_addr[1:0])
        FLD_FREQ:    rd_val = notch_freq_q[rd_idx];
        FLD_QUALITY: rd_val = notch_qual_q[rd_idx];
        FLD_DEPTH:   rd_val = notch_depth_q[rd_idx];
        default:     rd_val = 16'h0;
      endcase
    end else begin
      unique case (reg_addr)
        OFS_LOWPASS_FIRST:  rd_val = lowpass_first_q;
        OFS_LOWPASS_SECOND: rd_val = lowpass_second_q;
        OFS_SECOND_CUTOFF:  rd_val = cutoff_q;
        OFS_SECOND_QUALITY: rd_val = second_quality_q;
        OFS_AUTO_NOTCH_EN:  rd_val = auto_en_q;
        OFS_MID_SWITCH:     rd_val = mid_switch_q;
        OFS_JUDGE_LEVEL:    rd_val = judge_q;
        OFS_MID_DETECTED:   rd_val = mid_freq_q;
        OFS_STATUS: begin
          rd_val[STATUS_GAIN_BIT] = gain_second;
          rd_val[STATUS_MID_BIT]  = mid_active_q & mid_on;
        end
        default:            rd_val = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdata_q <= 16'h0;
    else rdata_q <= reg_read ? rd_val : 16'h0;
  end
  assign reg_rdata = rdata_q;

  // filter datapath
  state_t             state_q;
  logic [2:0]         stage_q;
  logic signed [31:0] x_q, chain_q, lpf_q;
  logic signed [31:0] lp_q [NUM_STAGES];
  logic signed [31:0] bp_q [NUM_STAGES];
  logic signed [15:0] out_q;
  logic               out_valid_q;

  // first-order low-pass on the selected set
  logic [15:0]        tf_sel;
  logic signed [31:0] alpha, lpf_diff, lpf_n;
  logic signed [63:0] lpf_prod;
  assign tf_sel   = gain_second ? lowpass_second_q : lowpass_first_q;
  assign alpha    = 32'((TS_NS << KEEP_FRAC) /
                    (longint'(tf_sel) * LOWPASS_UNIT_NS + TS_NS));
  assign lpf_diff = x_q - lpf_q;
  assign lpf_prod = 64'(lpf_diff) * 64'(alpha);
  assign lpf_n    = lpf_q + 32'(lpf_prod >>> KEEP_FRAC);

  // state-variable section shared by all shaping stages
  logic [1:0]         nidx;
  logic [15:0]        st_freq, st_qual, st_depth;
  logic signed [31:0] f_s, damp_s, supp_s;
  logic signed [31:0] lp_cur, bp_cur, lp_n, hp_v, bp_n, band, st_out;
  logic signed [63:0] p_lp, p_damp, p_bp, p_band, p_supp;
  assign nidx     = 2'(stage_q - 3'h1);
  assign st_freq  = (stage_q == 3'h0) ? cutoff_q
                  : (stage_q == MID_STAGE) ? mid_freq_q : notch_freq_q[nidx];
  assign st_qual  = (stage_q == 3'h0) ? second_quality_q
                  : (stage_q == MID_STAGE) ? NOTCH_QUALITY_RST
                  : notch_qual_q[nidx];
  assign st_depth = (stage_q == 3'h0) ? DEPTH_RST
                  : (stage_q == MID_STAGE)
                    ? ((mid_on && mid_active_q) ? MID_DEPTH : DEPTH_RST)
                  : notch_depth_q[nidx];
  assign f_s      = 32'((longint'(st_freq) * FREQ_GAIN) >>> 8);
  assign damp_s   = 32'((32'sd1 <<< COEF_FRAC) / 32'(st_qual));
  assign supp_s   = 32'(KEEP_ONE - db_keep(st_depth));
  assign lp_cur   = lp_q[stage_q];
  assign bp_cur   = bp_q[stage_q];
  assign p_lp     = 64'(f_s) * 64'(bp_cur);
  assign lp_n     = lp_cur + 32'(p_lp >>> COEF_FRAC);
  assign p_damp   = 64'(damp_s) * 64'(bp_cur);
  assign hp_v     = chain_q - lp_n - 32'(p_damp >>> COEF_FRAC);
  assign p_bp     = 64'(f_s) * 64'(hp_v);
  assign bp_n     = bp_cur + 32'(p_bp >>> COEF_FRAC);
  assign p_band   = 64'(damp_s) * 64'(bp_n);
  assign band     = 32'(p_band >>> COEF_FRAC);
  assign p_supp   = 64'(band) * 64'(supp_s);
  assign st_out   = (stage_q == 3'h0) ? lp_n
                  : chain_q - 32'(p_supp >>> KEEP_FRAC);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      stage_q     <= 3'h0;
      x_q         <= 32'sh0;
      chain_q     <= 32'sh0;
      lpf_q       <= 32'sh0;
      out_q       <= 16'sh0;
      out_valid_q <= 1'b0;
      for (int s = 0; s < NUM_STAGES; s++) begin
        lp_q[s] <= 32'sh0;
        bp_q[s] <= 32'sh0;
      end
    end else begin
      out_valid_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (sample_valid) begin
            x_q     <= 32'(torque_in) <<< STATE_FRAC;
            state_q <= ST_LOWPASS;
          end
        end
        ST_LOWPASS: begin
          lpf_q   <= lpf_n;
          chain_q <= lpf_n;
          stage_q <= 3'h0;
          state_q <= ST_SHAPE;
        end
        ST_SHAPE: begin
          lp_q[stage_q] <= lp_n;
          bp_q[stage_q] <= bp_n;
          chain_q       <= st_out;
          if (stage_q == LAST_STAGE) state_q <= ST_DONE;
          else stage_q <= stage_q + 3'h1;
        end
        ST_DONE: begin
          out_q       <= sat16(chain_q >>> STATE_FRAC);
          out_valid_q <= 1'b1;
          state_q     <= ST_IDLE;
        end
      endcase
    end
  end

  assign torque_out       = out_q;
  assign torque_out_valid = out_valid_q;
endmodule : servo_resonance_suppression
`default_nettype wire

// ===== verification/servo_resonance_suppression_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module resonance_checker
  import resonance_pkg::*;
(
  // clock and reset
  input wire logic                clock,
  input wire logic                arst_n,
  // register port
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_write,
  input wire logic                reg_read,
  input wire logic [DATA_W-1:0]   reg_rdata,
  // torque stream
  input wire logic                sample_valid,
  input wire logic signed [15:0]  torque_in,
  input wire logic signed [15:0]  speed_osc,
  input wire logic                gain_second,
  input wire logic signed [15:0]  torque_out,
  input wire logic                torque_out_valid
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire        take;
  // cycles left until the result of an accepted sample
  // result is registered at the 8th edge and sampled at the 9th
  assign take  = sample_valid && cnt_q <= 4'h1;
  assign cnt_d = take ? 4'h9 : (cnt_q != 4'h0 ? cnt_q - 4'h1 : cnt_q);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_out_latency: assert property (take |-> ##9 torque_out_valid)
    else $error("no result eight cycles after sample");
  chk_valid_pulse: assert property (torque_out_valid |=> !torque_out_valid)
    else $error("result pulse longer than one cycle");
  chk_valid_origin: assert property (torque_out_valid |-> cnt_q == 4'h1)
    else $error("result pulse without a sample");
  chk_out_hold: assert property ($changed(torque_out) |-> torque_out_valid)
    else $error("torque changed between results");
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  chk_hole_zero: assert property ((reg_read && reg_addr[7:4] == 4'h1 &&
    reg_addr[1:0] == 2'h3) |=> reg_rdata == '0)
    else $error("unused notch word not zero");
  chk_gain_status: assert property ((reg_read && reg_addr == OFS_STATUS)
    |=> reg_rdata[STATUS_GAIN_BIT] == $past(gain_second))
    else $error("status gain bit wrong");
  chk_lowpass_back: assert property ((reg_write &&
    reg_addr == OFS_LOWPASS_FIRST && reg_wdata >= LOWPASS_MIN &&
    reg_wdata <= LOWPASS_MAX) ##1 (reg_read && reg_addr == OFS_LOWPASS_FIRST)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("low-pass constant not kept");
  chk_depth_clamp: assert property ((reg_write && reg_addr == 8'h16 &&
    reg_wdata > DEPTH_MAX) ##1 (reg_read && reg_addr == 8'h16)
    |=> reg_rdata == DEPTH_MAX)
    else $error("depth not clamped");
endmodule : resonance_checker

bind servo_resonance_suppression resonance_checker i_resonance_checker (
  .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .torque_in(torque_in), .speed_osc(speed_osc), .gain_second(gain_second),
  .torque_out(torque_out), .torque_out_valid(torque_out_valid));
`default_nettype wire

// ===== verification/torque_source.sv
`timescale 1ns/1ps
`default_nettype none
module torque_source #(
  parameter int GAP = 10
) (
  // control from the bench
  input  wire logic               clock,
  input  wire logic               run_en,
  input  wire logic signed [15:0] level,
  input  wire logic [15:0]        osc_period,
  input  wire logic [15:0]        osc_amp,
  // toward the filter
  output var  logic               sample_valid,
  output var  logic signed [15:0] torque_in,
  output var  logic signed [15:0] speed_osc,
  // back from the filter
  input  wire logic signed [15:0] torque_out,
  input  wire logic               torque_out_valid,
  output var  logic signed [15:0] last_out
);
  int          tick = 0;
  logic [15:0] ph = '0;
  logic [15:0] per_q = '0;
  initial begin
    sample_valid = 1'b0;
    torque_in = '0;
    speed_osc = '0;
    last_out = '0;
  end
  // square speed ripple, rising crossing once per osc_period samples
  always @(posedge clock) begin
    sample_valid <= 1'b0;
    torque_in <= ~level;
    if (torque_out_valid) begin
      last_out <= torque_out;
    end
    if (run_en) begin
      tick <= (tick == GAP - 1) ? 0 : tick + 1;
      if (tick == GAP - 1) begin
        sample_valid <= 1'b1;
        torque_in <= level;
        per_q <= osc_period;
        ph <= (osc_period != per_q || ph + 16'h1 >= osc_period) ? '0 : ph + 16'h1;
        speed_osc <= (osc_period == '0) ? '0 :
          (ph < osc_period / 2 ? $signed(osc_amp) : -$signed(osc_amp));
      end
    end
  end
endmodule : torque_source
`default_nettype wire

// ===== verification/servo_resonance_suppression_tb.sv
`timescale 1ns/1ps
`default_nettype none
module servo_resonance_suppression_tb import resonance_pkg::*;;
  localparam int LIMIT = 60000;
  localparam logic [15:0] RV [8] = '{LOWPASS_RST, LOWPASS_RST, FREQ_MAX,
    SECOND_QUALITY_RST, 16'h0, 16'h0, JUDGE_LEVEL_RST, 16'h0};
  localparam logic [7:0] CA [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h11,
    8'h16, 8'h1c, 8'h07, 8'h0c};
  localparam logic [15:0] CD [9] = '{16'h0, 16'h1770, 16'h0032, 16'h00c8,
    16'h0, 16'h0063, 16'h000a, 16'h0037, 16'h0037};
  localparam logic [15:0] CE [9] = '{LOWPASS_MIN, LOWPASS_MAX,
    SECOND_CUTOFF_MIN, QUALITY_MAX, QUALITY_MIN, DEPTH_MAX, NOTCH_FREQ_MIN,
    16'h0, 16'h0};
  logic               clock;
  logic               arst_n;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata;
  logic               reg_write;
  logic               reg_read;
  logic [DATA_W-1:0]  reg_rdata;
  logic               sample_valid;
  logic signed [15:0] torque_in;
  logic signed [15:0] speed_osc;
  logic               gain_second;
  logic signed [15:0] torque_out;
  logic               torque_out_valid;
  logic               run_en;
  logic signed [15:0] level;
  logic [15:0]        osc_period;
  logic [15:0]        osc_amp;
  logic signed [15:0] last_out;
  int                 n_mismatch = 0;
  int                 n_checks = 0;
  int                 cyc = 0;

  servo_resonance_suppression #(.SAMPLE_HZ(40000)) i_servo_resonance_suppression (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .torque_in(torque_in), .speed_osc(speed_osc), .gain_second(gain_second),
    .torque_out(torque_out), .torque_out_valid(torque_out_valid));
  torque_source #(.GAP(10)) i_torque_source (
    .clock(clock), .run_en(run_en), .level(level), .osc_period(osc_period),
    .osc_amp(osc_amp), .sample_valid(sample_valid), .torque_in(torque_in),
    .speed_osc(speed_osc), .torque_out(torque_out),
    .torque_out_valid(torque_out_valid), .last_out(last_out));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic near(input string nm, input logic signed [15:0] e);
    logic signed [16:0] d;
    d = last_out - e;
    chk(nm, e, (d <= 2 && d >= -2) ? e : last_out);
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    // read data stand for this one cycle only
    @(negedge clock);
    chk($sformatf("reg_%h", a), e, reg_rdata);
    @(posedge clock);
  endtask : rd

  task automatic run(input int n);
    repeat (n * 10) @(posedge clock);
  endtask : run

  task automatic t_reset_values;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i), RV[i]);
    end
    rd(OFS_STATUS, 16'h0);
    for (int k = 0; k < 4; k++) begin
      rd(NOTCH_BASE + 8'(4 * k), FREQ_MAX);
      rd(NOTCH_BASE + 8'(4 * k + 1), NOTCH_QUALITY_RST);
      rd(NOTCH_BASE + 8'(4 * k + 2), DEPTH_RST);
      rd(NOTCH_BASE + 8'(4 * k + 3), 16'h0);
    end
  endtask : t_reset_values

  task automatic t_defaults_pass;
    level <= 16'sd1000;
    run(1500);
    near("pass", 16'sd1000);
  endtask : t_defaults_pass

  task automatic t_clamp;
    for (int i = 0; i < 9; i++) begin
      wr(CA[i], CD[i]);
      rd(CA[i], CE[i]);
    end
  endtask : t_clamp

  task automatic t_gain;
    wr(OFS_SECOND_QUALITY, 16'h0001);
    @(posedge clock);
    wr(OFS_SECOND_CUTOFF, FREQ_MAX);
    @(posedge clock);
    wr(OFS_LOWPASS_FIRST, 16'h0001);
    rd(OFS_LOWPASS_FIRST, 16'h0001);
    level <= 16'sd0;
    run(400);
    gain_second <= 1'b1;
    level <= 16'sd1000;
    run(20);
    rd(OFS_STATUS, 16'h0001);
    chk("slow", 16'h1, {15'h0, last_out < 16'sd250});
    gain_second <= 1'b0;
    run(400);
    near("fast", 16'sd1000);
  endtask : t_gain

  task automatic t_auto_notch;
    level <= 16'sd0;
    osc_amp <= 16'd100;
    osc_period <= 16'd200;
    run(400);
    wr(OFS_AUTO_NOTCH_EN, 16'h0001);
    run(800);
    rd(NOTCH_BASE, FREQ_MAX);
    wr(OFS_AUTO_NOTCH_EN, 16'h0000);
    osc_period <= 16'd20;
    run(200);
    rd(NOTCH_BASE, FREQ_MAX);
    wr(OFS_AUTO_NOTCH_EN, 16'h0001);
    run(200);
    rd(NOTCH_BASE, 16'h07d0);
    rd(NOTCH_BASE + 8'h02, AUTO_DEPTH);
    wr(OFS_AUTO_NOTCH_EN, 16'h0000);
  endtask : t_auto_notch

  task automatic t_mid;
    osc_amp <= 16'd5;
    osc_period <= 16'd40;
    run(20);
    wr(OFS_MID_SWITCH, 16'h0005);
    rd(OFS_MID_SWITCH, MID_SWITCH_ON);
    run(320);
    rd(OFS_MID_DETECTED, 16'h0);
    osc_amp <= 16'd50;
    run(320);
    rd(OFS_MID_DETECTED, 16'h03e8);
    rd(OFS_STATUS, 16'h0002);
    wr(OFS_MID_SWITCH, 16'h0001);
    rd(OFS_STATUS, 16'h0);
    rd(OFS_MID_DETECTED, 16'h03e8);
  endtask : t_mid

  initial begin
    arst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    gain_second = 1'b0;
    run_en = 1'b0;
    level = '0;
    osc_period = '0;
    osc_amp = '0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    run_en <= 1'b1;
    t_reset_values();
    t_defaults_pass();
    t_clamp();
    t_gain();
    t_auto_notch();
    t_mid();
    complete_run();
  end
endmodule : servo_resonance_suppression_tb
`default_nettype wire
